// ---- core/easm_pkg.sv ----
package easm_pkg;
  // Clock rate and time base.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Analog loop current window in microamps.
  localparam logic [15:0] AIN_LOW_UA = 16'h07D0;
  localparam logic [15:0] AIN_HIGH_UA = 16'h55F0;
  // Setting limits: delays in 10 ms ticks, levels in 0.1 percent, speed in rpm.
  localparam logic [15:0] ALARM_DELAY_MIN = 16'h0001;
  localparam logic [15:0] ALARM_DELAY_MAX = 16'h1770;
  localparam logic [15:0] PID_TIME_MAX = 16'h2EE0;
  localparam logic [15:0] LEVEL_MAX = 16'h03E8;
  localparam logic [15:0] SHUTDOWN_RPM_MIN = 16'h0001;
  localparam logic [15:0] SHUTDOWN_RPM_MAX = 16'h0898;
  // Alarm vector bit positions.
  localparam int unsigned AL_SPD1 = 0;
  localparam int unsigned AL_SPD2 = 1;
  localparam int unsigned AL_MANAIR = 2;
  localparam int unsigned AL_REMSPD = 3;
  localparam int unsigned AL_RACK = 4;
  localparam int unsigned AL_SPDSW = 5;
  localparam int unsigned AL_TORQUE = 6;
  localparam int unsigned AL_MANLIM = 7;
  localparam int unsigned AL_HIACT = 8;
  localparam int unsigned AL_PORT3 = 9;
  localparam int unsigned AL_NET1 = 10;
  localparam int unsigned AL_NET2 = 11;
  localparam int unsigned AL_NETBOTH = 12;
  localparam int unsigned AL_PIDLOW = 13;
  localparam int unsigned AL_OVERSPD = 14;
  localparam int unsigned AL_LOADSW = 15;
  localparam int unsigned AL_CLUTCH = 16;
  localparam int unsigned ALARM_W = 17;
  // Alarms that follow their condition without a reset.
  localparam logic [16:0] NONLATCH_MASK = 17'h0_C0E0;
  localparam logic [16:0] ENABLE_RESET = 17'h0_0000;
  localparam logic [15:0] SETTING_RESET = 16'h0000;
  // Register byte offsets.
  localparam logic [7:0] REG_MINOR_EN = 8'h00;
  localparam logic [7:0] REG_MAJOR_EN = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_ALARM_DLY = 8'h0C;
  localparam logic [7:0] REG_PID_LEVEL = 8'h10;
  localparam logic [7:0] REG_PID_TIME = 8'h14;
  localparam logic [7:0] REG_HIACT_LEVEL = 8'h18;
  localparam logic [7:0] REG_SHUTDOWN_RPM = 8'h1C;
  localparam logic [7:0] REG_NET_DLY = 8'h20;
  localparam logic [7:0] REG_SPDSW_PICKUP = 8'h24;
  localparam logic [7:0] REG_SPDSW_DROP = 8'h28;
  localparam logic [7:0] REG_LOAD_PICKUP = 8'h2C;
  localparam logic [7:0] REG_CLUTCH_TIME = 8'h30;
  localparam logic [7:0] REG_LIVE = 8'h34;
  localparam logic [7:0] REG_LATCHED = 8'h38;
  localparam logic [7:0] REG_STATUS = 8'h3C;
  // Control register bit positions.
  localparam int unsigned CTRL_MINOR_OPEN = 0;
  localparam int unsigned CTRL_MAJOR_OPEN = 1;
  localparam int unsigned CTRL_SD_PID = 2;
  localparam int unsigned CTRL_RESET_ALL = 3;
endpackage

// ---- core/easm_qual_timer.sv ----
`timescale 1ns/1ps
module easm_qual_timer
  import easm_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Time base and condition.
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  // Qualified result.
  output logic qualified
);
  logic [W-1:0] cnt_q;

  // Counts ticks while the condition holds; any gap restarts from zero.
  always_ff @(posedge clk) begin
    if (!rst_n || !cond) begin
      cnt_q <= '0;
    end else if (tick && cnt_q < limit) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign qualified = cond && (cnt_q >= limit);
endmodule

// ---- core/easm_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// R1: Analog input fails after staying outside 2.0-22 mA for the alarm delay.
// R2: Minor relay energizes on alarm unless open-on-alarm selected, then de-energizes.
// R3: Major relay energizes on alarm unless open-on-alarm selected, then de-energizes.
// R4: A condition reaches the minor output only when its minor enable is set.
// R5: Any enabled major condition, alone or combined, activates the major output.
// R6: With shutdown on PID zero set, PID low alarm commands emergency declutch.
// R7: PID low alarm after output below level continuously for configured time.
// R8: High actuator alarm trips when PID output exceeds its level.
// R9: Shutdown setpoint held within 1-2200 rpm; overspeed flag above trip point.
// R10: Network and port 3 errors latch only after the network alarm delay.
// R11: Major indicator true while any enabled major alarm occurred or is active.
// R12: Speed switch sets above pickup, clears only below separate dropout.
// R13: Both-channels error only while both network channels are in error.
// R14: Clutch fail when engaged contact missing past sync time; clears on contact. Code latches AL_CLUTCH until reset-all; only the live flag clears.
// R15: Rising reset-all clears every latched alarm whose condition has cleared.
// R16: Limiter flags follow torque, manifold and maximum fuel limiter control.
// R17: Load switch flag follows load above its pickup setpoint.
// R18: Port 3 error follows the link or hardware error of the port.
// R19: Each speed sensor has its own failure flag following its health.
// R20: Enabled conditions are ORed into each relay output.
// R21: Speed switch, limiter and load switch alarms are non-latching; max fuel limiting sets the high actuator alarm, which latches.
// R22: Qualification timers restart from zero when the condition clears early.
// R23: Latching alarms stay set until a reset-all rising transition.
module easm_top
  import easm_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic NRST,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Analog loop currents in microamps.
  input wire logic [15:0] RACK_IN_UA,
  input wire logic [15:0] REMOTE_SPEED_UA,
  input wire logic [15:0] MANIFOLD_AIR_UA,
  // Speed, load and control-loop status.
  input wire logic SPEED_SENSOR1_FAIL,
  input wire logic SPEED_SENSOR2_FAIL,
  input wire logic [15:0] ENGINE_RPM,
  input wire logic [15:0] ENGINE_LOAD,
  input wire logic [15:0] PID_OUTPUT,
  input wire logic TORQUE_LIMITING,
  input wire logic MANIFOLD_LIMITING,
  input wire logic MAX_FUEL_LIMITING,
  input wire logic CLUTCH_COMMANDED,
  input wire logic CLUTCH_ENGAGED,
  // Network and serial port errors.
  input wire logic NET_CHANNEL1_ERROR,
  input wire logic NET_CHANNEL2_ERROR,
  input wire logic SERIAL_PORT3_ERROR,
  // Relay drives and indicators.
  output logic MINOR_RELAY,
  output logic MAJOR_RELAY,
  output logic MINOR_ALARM_INDICATOR,
  output logic MAJOR_ALARM_INDICATOR,
  output logic EMERGENCY_DECLUTCH
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic out_of_window(input logic [15:0] ua);
    out_of_window = (ua < AIN_LOW_UA) || (ua > AIN_HIGH_UA);
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [ALARM_W-1:0] minor_en_q;
  logic [ALARM_W-1:0] major_en_q;
  logic [3:0] ctrl_q;
  logic [15:0] alarm_dly_q;
  logic [15:0] pid_level_q;
  logic [15:0] pid_time_q;
  logic [15:0] hiact_level_q;
  logic [15:0] shutdown_rpm_q;
  logic [15:0] net_dly_q;
  logic [15:0] spdsw_pickup_q;
  logic [15:0] spdsw_drop_q;
  logic [15:0] load_pickup_q;
  logic [15:0] clutch_time_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [ALARM_W-1:0] live;
  logic [ALARM_W-1:0] latched_q;
  logic minor_act;
  logic major_act;
  logic acc;
  logic [15:0] wd;

  assign acc = HSEL && HREADY && HTRANS[1];
  assign wd = HWDATA[15:0];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc && HWRITE;
      wr_addr_q <= HADDR[7:0];
    end
  end

  // Alarm delay, PID, high actuator and shutdown settings are clamped on write; the rest are stored as written.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      minor_en_q <= ENABLE_RESET;
      major_en_q <= ENABLE_RESET;
      ctrl_q <= 4'h0;
      alarm_dly_q <= ALARM_DELAY_MIN;
      pid_level_q <= SETTING_RESET;
      pid_time_q <= SETTING_RESET;
      hiact_level_q <= LEVEL_MAX;
      shutdown_rpm_q <= SHUTDOWN_RPM_MAX;
      net_dly_q <= SETTING_RESET;
      spdsw_pickup_q <= SETTING_RESET;
      spdsw_drop_q <= SETTING_RESET;
      load_pickup_q <= SETTING_RESET;
      clutch_time_q <= SETTING_RESET;
    end else if (wr_pend_q) begin
      if (wr_addr_q == REG_MINOR_EN) begin
        minor_en_q <= HWDATA[ALARM_W-1:0];
      end else if (wr_addr_q == REG_MAJOR_EN) begin
        major_en_q <= HWDATA[ALARM_W-1:0];
      end else if (wr_addr_q == REG_CTRL) begin
        ctrl_q <= HWDATA[3:0];
      end else if (wr_addr_q == REG_ALARM_DLY) begin
        alarm_dly_q <= clamp16(wd, ALARM_DELAY_MIN, ALARM_DELAY_MAX); // R1
      end else if (wr_addr_q == REG_PID_LEVEL) begin
        pid_level_q <= clamp16(wd, SETTING_RESET, LEVEL_MAX); // R7
      end else if (wr_addr_q == REG_PID_TIME) begin
        pid_time_q <= clamp16(wd, SETTING_RESET, PID_TIME_MAX); // R7
      end else if (wr_addr_q == REG_HIACT_LEVEL) begin
        hiact_level_q <= clamp16(wd, SETTING_RESET, LEVEL_MAX); // R8
      end else if (wr_addr_q == REG_SHUTDOWN_RPM) begin
        shutdown_rpm_q <= clamp16(wd, SHUTDOWN_RPM_MIN, SHUTDOWN_RPM_MAX); // R9
      end else if (wr_addr_q == REG_NET_DLY) begin
        net_dly_q <= wd;
      end else if (wr_addr_q == REG_SPDSW_PICKUP) begin
        spdsw_pickup_q <= wd;
      end else if (wr_addr_q == REG_SPDSW_DROP) begin
        spdsw_drop_q <= wd;
      end else if (wr_addr_q == REG_LOAD_PICKUP) begin
        load_pickup_q <= wd;
      end else if (wr_addr_q == REG_CLUTCH_TIME) begin
        clutch_time_q <= wd;
      end
    end
  end

  // Read data is registered in the address phase and stands in the data phase.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc && !HWRITE) begin
      if (HADDR[7:0] == REG_MINOR_EN) begin
        rdata_q <= 32'(minor_en_q);
      end else if (HADDR[7:0] == REG_MAJOR_EN) begin
        rdata_q <= 32'(major_en_q);
      end else if (HADDR[7:0] == REG_CTRL) begin
        rdata_q <= 32'(ctrl_q);
      end else if (HADDR[7:0] == REG_ALARM_DLY) begin
        rdata_q <= 32'(alarm_dly_q);
      end else if (HADDR[7:0] == REG_PID_LEVEL) begin
        rdata_q <= 32'(pid_level_q);
      end else if (HADDR[7:0] == REG_PID_TIME) begin
        rdata_q <= 32'(pid_time_q);
      end else if (HADDR[7:0] == REG_HIACT_LEVEL) begin
        rdata_q <= 32'(hiact_level_q);
      end else if (HADDR[7:0] == REG_SHUTDOWN_RPM) begin
        rdata_q <= 32'(shutdown_rpm_q);
      end else if (HADDR[7:0] == REG_NET_DLY) begin
        rdata_q <= 32'(net_dly_q);
      end else if (HADDR[7:0] == REG_SPDSW_PICKUP) begin
        rdata_q <= 32'(spdsw_pickup_q);
      end else if (HADDR[7:0] == REG_SPDSW_DROP) begin
        rdata_q <= 32'(spdsw_drop_q);
      end else if (HADDR[7:0] == REG_LOAD_PICKUP) begin
        rdata_q <= 32'(load_pickup_q);
      end else if (HADDR[7:0] == REG_CLUTCH_TIME) begin
        rdata_q <= 32'(clutch_time_q);
      end else if (HADDR[7:0] == REG_LIVE) begin
        rdata_q <= 32'(live);
      end else if (HADDR[7:0] == REG_LATCHED) begin
        rdata_q <= 32'(latched_q);
      end else if (HADDR[7:0] == REG_STATUS) begin
        rdata_q <= {27'h000_0000, EMERGENCY_DECLUTCH, MAJOR_RELAY, MINOR_RELAY,
                    major_act, minor_act};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic [$clog2(TICK_CYCLES)-1:0] div_q;
  logic tick;

  assign tick = (div_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

  always_ff @(posedge CORE_CLK) begin
    if (!NRST || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fault conditions
  // ----------------------------------------------------------------
  logic [4:0] raw_q;
  logic [4:0] qual;
  logic [15:0] limits [5];
  logic spdsw_q;
  logic clutch_wait;

  assign raw_q[0] = out_of_window(RACK_IN_UA);
  assign raw_q[1] = out_of_window(REMOTE_SPEED_UA);
  assign raw_q[2] = out_of_window(MANIFOLD_AIR_UA);
  assign raw_q[3] = PID_OUTPUT < pid_level_q; // R7
  assign raw_q[4] = clutch_wait;
  assign clutch_wait = CLUTCH_COMMANDED && !CLUTCH_ENGAGED; // R14
  assign limits[0] = alarm_dly_q;
  assign limits[1] = alarm_dly_q;
  assign limits[2] = alarm_dly_q;
  assign limits[3] = pid_time_q;
  assign limits[4] = clutch_time_q;

  for (genvar i = 0; i < 5; i++) begin : g_qual
    easm_qual_timer #(.W(16)) u_timer (
      .clk(CORE_CLK),
      .rst_n(NRST),
      .tick(tick),
      .cond(raw_q[i]),
      .limit(limits[i]),
      .qualified(qual[i])
    ); // R1 R22
  end

  // Hysteresis speed switch.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      spdsw_q <= 1'b0;
    end else if (ENGINE_RPM > spdsw_pickup_q) begin
      spdsw_q <= 1'b1; // R12
    end else if (ENGINE_RPM < spdsw_drop_q) begin
      spdsw_q <= 1'b0; // R12
    end
  end

  always_comb begin
    live = '0;
    live[AL_SPD1] = SPEED_SENSOR1_FAIL; // R19
    live[AL_SPD2] = SPEED_SENSOR2_FAIL; // R19
    live[AL_RACK] = qual[0]; // R1
    live[AL_REMSPD] = qual[1];
    live[AL_MANAIR] = qual[2];
    live[AL_SPDSW] = spdsw_q;
    live[AL_TORQUE] = TORQUE_LIMITING; // R16
    live[AL_MANLIM] = MANIFOLD_LIMITING; // R16
    live[AL_HIACT] = MAX_FUEL_LIMITING || (PID_OUTPUT > hiact_level_q); // R8 R16
    live[AL_PORT3] = SERIAL_PORT3_ERROR; // R18
    live[AL_NET1] = NET_CHANNEL1_ERROR;
    live[AL_NET2] = NET_CHANNEL2_ERROR;
    live[AL_NETBOTH] = NET_CHANNEL1_ERROR && NET_CHANNEL2_ERROR; // R13
    live[AL_PIDLOW] = qual[3]; // R7
    live[AL_OVERSPD] = ENGINE_RPM > shutdown_rpm_q; // R9
    live[AL_LOADSW] = ENGINE_LOAD > load_pickup_q; // R17
    live[AL_CLUTCH] = qual[4]; // R14
  end

  // ----------------------------------------------------------------
  // Network delay
  // ----------------------------------------------------------------
  logic [2:0] net_qual;
  logic [2:0] net_raw;

  assign net_raw = {live[AL_PORT3], live[AL_NET2], live[AL_NET1]};

  for (genvar j = 0; j < 3; j++) begin : g_net
    easm_qual_timer #(.W(16)) u_net (
      .clk(CORE_CLK),
      .rst_n(NRST),
      .tick(tick),
      .cond(net_raw[j]),
      .limit(net_dly_q),
      .qualified(net_qual[j])
    ); // R10 R22
  end

  // ----------------------------------------------------------------
  // Latching and reset
  // ----------------------------------------------------------------
  logic reset_all_q;
  logic reset_rise;
  logic [ALARM_W-1:0] set_vec;

  assign reset_rise = ctrl_q[CTRL_RESET_ALL] && !reset_all_q; // R15

  always_comb begin
    set_vec = live;
    set_vec[AL_NET1] = net_qual[0]; // R10
    set_vec[AL_NET2] = net_qual[1]; // R10
    set_vec[AL_PORT3] = net_qual[2]; // R10
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      reset_all_q <= 1'b0;
    end else begin
      reset_all_q <= ctrl_q[CTRL_RESET_ALL];
    end
  end

  // A present condition wins over the reset; cleared conditions are dropped.
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      latched_q <= '0;
    end else if (reset_rise) begin
      latched_q <= set_vec & ~NONLATCH_MASK; // R15
    end else begin
      latched_q <= (latched_q | set_vec) & ~NONLATCH_MASK; // R23
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [ALARM_W-1:0] active;

  assign active = latched_q | (set_vec & NONLATCH_MASK); // R21
  assign minor_act = |(active & minor_en_q); // R4 R20
  assign major_act = |(active & major_en_q); // R5 R11 R20

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      MINOR_RELAY <= 1'b0;
      MAJOR_RELAY <= 1'b0;
      MINOR_ALARM_INDICATOR <= 1'b0;
      MAJOR_ALARM_INDICATOR <= 1'b0;
      EMERGENCY_DECLUTCH <= 1'b0;
    end else begin
      MINOR_RELAY <= minor_act ^ ctrl_q[CTRL_MINOR_OPEN]; // R2
      MAJOR_RELAY <= major_act ^ ctrl_q[CTRL_MAJOR_OPEN]; // R3
      MINOR_ALARM_INDICATOR <= minor_act;
      MAJOR_ALARM_INDICATOR <= major_act; // R11
      EMERGENCY_DECLUTCH <= ctrl_q[CTRL_SD_PID] && active[AL_PIDLOW]; // R6
    end
  end
endmodule

// ---- sim/easm_checker.sv ----
`timescale 1ns/1ps
module easm_checker
  import easm_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Register bus.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  // Conditions and outputs.
  input wire logic TORQUE_LIMITING,
  input wire logic MINOR_RELAY,
  input wire logic MAJOR_RELAY,
  input wire logic MINOR_ALARM_INDICATOR,
  input wire logic MAJOR_ALARM_INDICATOR,
  input wire logic EMERGENCY_DECLUTCH
);
  // ----------------------------------------
  // Shadow of the configuration written over the bus
  // ----------------------------------------
  logic wr_q;
  logic [7:0] wa_q;
  logic [16:0] minor_en_q;
  logic [16:0] major_en_q;
  logic [2:0] ctrl_q;
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
      wa_q <= HADDR[7:0];
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      minor_en_q <= '0;
      major_en_q <= '0;
      ctrl_q <= 3'h0;
    end else if (wr_q) begin
      if (wa_q == REG_MINOR_EN) minor_en_q <= HWDATA[16:0];
      if (wa_q == REG_MAJOR_EN) major_en_q <= HWDATA[16:0];
      if (wa_q == REG_CTRL) ctrl_q <= HWDATA[2:0];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  a_minor_polarity: assert property (
    ctrl_q[0] == $past(ctrl_q[0]) |-> MINOR_RELAY == (MINOR_ALARM_INDICATOR ^ ctrl_q[0]))
    else $error("minor relay polarity wrong");
  a_major_polarity: assert property (
    ctrl_q[1] == $past(ctrl_q[1]) |-> MAJOR_RELAY == (MAJOR_ALARM_INDICATOR ^ ctrl_q[1]))
    else $error("major relay polarity wrong");
  a_minor_gate: assert property (
    (minor_en_q == '0) [*3] |-> !MINOR_ALARM_INDICATOR)
    else $error("minor alarm without enable");
  a_major_gate: assert property (
    (major_en_q == '0) [*3] |-> !MAJOR_ALARM_INDICATOR)
    else $error("major alarm without enable");
  a_torque_follow: assert property (
    (minor_en_q == 17'h0_0040 && TORQUE_LIMITING) [*3] |-> MINOR_ALARM_INDICATOR)
    else $error("torque limiting not shown");
  a_torque_release: assert property (
    (minor_en_q == 17'h0_0040 && !TORQUE_LIMITING) [*3] |-> !MINOR_ALARM_INDICATOR)
    else $error("torque alarm held after release");
  a_minor_any: assert property (
    (minor_en_q == 17'h1_FFFF && TORQUE_LIMITING) [*3] |-> MINOR_ALARM_INDICATOR)
    else $error("or of enabled alarms missing");
  a_major_torque: assert property (
    (major_en_q[AL_TORQUE] && TORQUE_LIMITING) [*3] |-> MAJOR_ALARM_INDICATOR)
    else $error("major alarm missing");
  a_declutch_cause: assert property (
    EMERGENCY_DECLUTCH |-> $past(ctrl_q[2]) || $past(ctrl_q[2], 2))
    else $error("declutch without shutdown setting");
  c_declutch: cover property (EMERGENCY_DECLUTCH);
  c_both: cover property (MINOR_ALARM_INDICATOR && MAJOR_ALARM_INDICATOR);
  c_open: cover property (ctrl_q[0] && MINOR_RELAY);
endmodule

bind easm_top easm_checker i_easm_checker (.CORE_CLK(CORE_CLK), .NRST(NRST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .TORQUE_LIMITING(TORQUE_LIMITING), .MINOR_RELAY(MINOR_RELAY), .MAJOR_RELAY(MAJOR_RELAY),
  .MINOR_ALARM_INDICATOR(MINOR_ALARM_INDICATOR), .MAJOR_ALARM_INDICATOR(MAJOR_ALARM_INDICATOR),
  .EMERGENCY_DECLUTCH(EMERGENCY_DECLUTCH));

// ---- sim/easm_plant_model.sv ----
`timescale 1ns/1ps
module easm_plant_model
  import easm_pkg::*;
(
  // Commanded faults, one bit per alarm position.
  input wire logic [16:0] fault,
  // Sensor and loop status towards the monitor.
  output logic [15:0] rack_ua,
  output logic [15:0] rspd_ua,
  output logic [15:0] mair_ua,
  output logic spd1,
  output logic spd2,
  output logic torque,
  output logic manlim,
  output logic maxfuel,
  output logic port3,
  output logic net1,
  output logic net2,
  output logic clutch_cmd,
  output logic clutch_eng
);
  // Failed loops sit outside the window.
  assign rack_ua = fault[AL_RACK] ? 16'h0064 : 16'h2EE0;
  assign rspd_ua = fault[AL_REMSPD] ? 16'h0064 : 16'h2EE0;
  assign mair_ua = fault[AL_MANAIR] ? 16'h6000 : 16'h2EE0;
  assign spd1 = fault[AL_SPD1];
  assign spd2 = fault[AL_SPD2];
  assign torque = fault[AL_TORQUE];
  assign manlim = fault[AL_MANLIM];
  assign maxfuel = fault[AL_HIACT];
  assign port3 = fault[AL_PORT3];
  assign net1 = fault[AL_NET1];
  assign net2 = fault[AL_NET2];
  // The clutch is always commanded.
  assign clutch_cmd = 1'b1;
  assign clutch_eng = !fault[AL_CLUTCH];
endmodule

// ---- sim/easm_top_test.sv ----
`timescale 1ns/1ps
module easm_top_test
  import easm_pkg::*;
();
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [16:0] fault = 17'h0_0000;
  logic [15:0] rpm = 16'h01F4;
  logic [15:0] load = 16'h0064;
  logic [15:0] pid = 16'h01F4;
  logic [31:0] hrdata;
  logic hreadyout, hresp, minor_relay, major_relay, minor_ind, major_ind, declutch;
  logic [15:0] rack_ua, rspd_ua, mair_ua;
  logic spd1, spd2, torque, manlim, maxfuel, port3, net1, net2, clutch_cmd, clutch_eng;
  int fails = 0;
  int comparisons = 0;
  int unsigned nl[5] = '{AL_SPDSW, AL_TORQUE, AL_MANLIM, AL_OVERSPD, AL_LOADSW};

  easm_plant_model i_easm_plant_model (.fault(fault), .rack_ua(rack_ua), .rspd_ua(rspd_ua),
    .mair_ua(mair_ua), .spd1(spd1), .spd2(spd2), .torque(torque), .manlim(manlim),
    .maxfuel(maxfuel), .port3(port3), .net1(net1), .net2(net2), .clutch_cmd(clutch_cmd),
    .clutch_eng(clutch_eng));
  easm_top i_easm_top (.CORE_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RACK_IN_UA(rack_ua),
    .REMOTE_SPEED_UA(rspd_ua), .MANIFOLD_AIR_UA(mair_ua), .SPEED_SENSOR1_FAIL(spd1),
    .SPEED_SENSOR2_FAIL(spd2), .ENGINE_RPM(rpm), .ENGINE_LOAD(load), .PID_OUTPUT(pid),
    .TORQUE_LIMITING(torque), .MANIFOLD_LIMITING(manlim), .MAX_FUEL_LIMITING(maxfuel),
    .CLUTCH_COMMANDED(clutch_cmd), .CLUTCH_ENGAGED(clutch_eng), .NET_CHANNEL1_ERROR(net1),
    .NET_CHANNEL2_ERROR(net2), .SERIAL_PORT3_ERROR(port3), .MINOR_RELAY(minor_relay),
    .MAJOR_RELAY(major_relay), .MINOR_ALARM_INDICATOR(minor_ind),
    .MAJOR_ALARM_INDICATOR(major_ind), .EMERGENCY_DECLUTCH(declutch));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(hrdata, exp);
  endtask
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic sr(input logic [7:0] a, input logic [31:0] exp);
    settle();
    rd_reg(a, exp);
  endtask
  // Expected vector is {declutch, major relay, minor relay, major, minor}.
  task automatic outs(input logic [4:0] exp);
    settle();
    chk({27'h000_0000, declutch, major_relay, minor_relay, major_ind, minor_ind},
        32'(exp));
  endtask
  task automatic cond(input int unsigned b, input logic on);
    if (b == AL_SPDSW) rpm <= on ? 16'h04B0 : 16'h01F4;
    else if (b == AL_OVERSPD) rpm <= on ? 16'h0708 : 16'h01F4;
    else if (b == AL_LOADSW) load <= on ? 16'h0258 : 16'h0064;
    else fault[b] <= on;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(REG_ALARM_DLY, 32'h0000_0001);
    rd_reg(REG_HIACT_LEVEL, 32'h0000_03E8);
    rd_reg(REG_SHUTDOWN_RPM, 32'h0000_0898);
    rd_reg(8'h40, 32'h0000_0000);
    wr_reg(REG_SHUTDOWN_RPM, 32'h0000_0BB8);
    rd_reg(REG_SHUTDOWN_RPM, 32'h0000_0898);
    wr_reg(REG_SHUTDOWN_RPM, 32'h0000_0000);
    rd_reg(REG_SHUTDOWN_RPM, 32'h0000_0001);
    wr_reg(REG_SHUTDOWN_RPM, 32'h0000_05DC);
    wr_reg(REG_SPDSW_PICKUP, 32'h0000_03E8);
    wr_reg(REG_SPDSW_DROP, 32'h0000_0320);
    wr_reg(REG_LOAD_PICKUP, 32'h0000_01F4);
    wr_reg(REG_PID_LEVEL, 32'h0000_0064);
    wr_reg(REG_HIACT_LEVEL, 32'h0000_0258);
    // No loop failure inside the delay.
    wr_reg(REG_MINOR_EN, 32'h0000_0010);
    cond(AL_RACK, 1'b1);
    repeat (50) @(posedge clk);
    outs(5'b0_0000);
    rd_reg(REG_LATCHED, 32'h0000_0000);
    cond(AL_RACK, 1'b0);
    foreach (nl[i]) begin
      wr_reg(REG_MINOR_EN, 32'h0000_0001 << nl[i]);
      cond(nl[i], 1'b1);
      outs(5'b0_0101);
      wr_reg(REG_MINOR_EN, 32'h0000_0000);
      outs(5'b0_0000);
      wr_reg(REG_MINOR_EN, 32'h0000_0001 << nl[i]);
      cond(nl[i], 1'b0);
      outs(5'b0_0000);
    end
    wr_reg(REG_MINOR_EN, 32'h0001_FFFF);
    cond(AL_TORQUE, 1'b1);
    outs(5'b0_0101);
    wr_reg(REG_MAJOR_EN, 32'h0000_0040);
    outs(5'b0_1111);
    wr_reg(REG_CTRL, 32'h0000_0003);
    outs(5'b0_0011);
    cond(AL_TORQUE, 1'b0);
    outs(5'b0_1100);
    wr_reg(REG_CTRL, 32'h0000_0000);
    wr_reg(REG_MINOR_EN, 32'h0000_0000);
    rpm <= 16'h04B0;
    sr(REG_LIVE, 32'h0000_0020);
    rpm <= 16'h0384;
    sr(REG_LIVE, 32'h0000_0020);
    rpm <= 16'h02BC;
    sr(REG_LIVE, 32'h0000_0000);
    // Latching and reset-all.
    wr_reg(REG_MAJOR_EN, 32'h0000_0003);
    fault[1:0] <= 2'b11;
    sr(REG_LIVE, 32'h0000_0003);
    fault[AL_SPD1] <= 1'b0;
    sr(REG_LIVE, 32'h0000_0002);
    rd_reg(REG_LATCHED, 32'h0000_0003);
    outs(5'b0_1010);
    wr_reg(REG_CTRL, 32'h0000_0008);
    sr(REG_LATCHED, 32'h0000_0002);
    fault[AL_SPD2] <= 1'b0;
    sr(REG_LATCHED, 32'h0000_0002);
    wr_reg(REG_CTRL, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_0008);
    sr(REG_LATCHED, 32'h0000_0000);
    outs(5'b0_0000);
    wr_reg(REG_CTRL, 32'h0000_0000);
    pid <= 16'h0032;
    sr(REG_LATCHED, 32'h0000_2000);
    outs(5'b0_0000);
    wr_reg(REG_CTRL, 32'h0000_0004);
    outs(5'b1_0000);
    pid <= 16'h01F4;
    wr_reg(REG_CTRL, 32'h0000_000C);
    sr(REG_LATCHED, 32'h0000_0000);
    outs(5'b0_0000);
    pid <= 16'h02BC;
    sr(REG_LIVE, 32'h0000_0100);
    pid <= 16'h01F4;
    fault[AL_HIACT] <= 1'b1;
    sr(REG_LIVE, 32'h0000_0100);
    fault <= 17'h0_0400;
    sr(REG_LIVE, 32'h0000_0400);
    fault <= 17'h0_0C00;
    sr(REG_LIVE, 32'h0000_1C00);
    fault <= 17'h0_0A00;
    sr(REG_LIVE, 32'h0000_0A00);
    fault <= 17'h1_0000;
    sr(REG_LIVE, 32'h0001_0000);
    fault <= 17'h0_0000;
    sr(REG_LIVE, 32'h0000_0000);
    complete_run();
  end
endmodule
